// ===== rtl/csgeq_top.sv
// Behaviour
// (R01) Bit 15 and unused bits read zero.
// (R02) Condition bit 9 follows serial group one.
// (R03) Condition bit 8 follows serial group two.
// (R04) Link failure bits 1 and 0 never set.
// (R05) One summary output toward parent hardware group.
// (R06) Controller enables summary in parent group first.
// (R07) Event latch clears on read or clear-status.
// (R08) Rise and fall filters readable and writable.
// (R09) Event mask readable and writable.
// (R10) Filtered edges set events; summary ORs enabled.
// (R11) Error queue holds twenty entries first-in first-out.
// (R12) Queue gives no message-available summary.
// (R13) Rising error bits push one entry.
// (R14) Entry answers number first, then description.
// (R15) Description length at most 255 characters.
// (R16) Full queue replaces newest with overflow entry.
// (R17) Empty queue answers code zero, no error.
// (R18) Each read returns and removes oldest.
// (R19) Controller reads number then string.
module csgeq_top (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic SER1_SMB_I,
    input wire logic SER2_SMB_I,
    input wire logic [csgeq_pkg::SEL_W-1:0] REG_SEL_I,
    input wire logic RD_STB_I,
    input wire logic WR_STB_I,
    input wire logic [csgeq_pkg::REG_W-1:0] WR_DATA_I,
    input wire logic CLS_I,
    output logic [csgeq_pkg::REG_W-1:0] RD_DATA_O,
    output logic RD_VALID_O,
    output logic SUMMARY_MSG_O,
    input wire logic [csgeq_pkg::ESR_ERR_W-1:0] ESR_ERR_I,
    input wire logic [csgeq_pkg::CODE_W-1:0] ERR_CODE_I,
    input wire logic [csgeq_pkg::DESC_W-1:0] ERR_DESC_ID_I,
    input wire logic [csgeq_pkg::DESC_W-1:0] ERR_DESC_LEN_I,
    input wire logic ERR_RD_STB_I,
    output logic [csgeq_pkg::CODE_W-1:0] ERR_CODE_O,
    output logic [csgeq_pkg::DESC_W-1:0] ERR_DESC_ID_O,
    output logic [csgeq_pkg::DESC_W-1:0] ERR_DESC_LEN_O,
    output logic ERR_VALID_O
);

    // Advance a queue pointer with wrap at the last slot.
    function automatic logic [csgeq_pkg::PTR_W-1:0] ptr_inc(
        input logic [csgeq_pkg::PTR_W-1:0] p);
        ptr_inc = (p == csgeq_pkg::LAST_IDX) ? '0 : p + 5'h01;
    endfunction

    // Step a queue pointer back with wrap at slot zero.
    function automatic logic [csgeq_pkg::PTR_W-1:0] ptr_dec(
        input logic [csgeq_pkg::PTR_W-1:0] p);
        ptr_dec = (p == '0) ? csgeq_pkg::LAST_IDX : p - 5'h01;
    endfunction

    logic [15:0] cond_reg; // Sampled condition bits.
    logic [15:0] cond_next; // Condition bits as seen this cycle.
    logic [15:0] rise_reg; // Rising-edge filter.
    logic [15:0] fall_reg; // Falling-edge filter.
    logic [15:0] event_reg; // Latched events.
    logic [15:0] event_next; // Next event latch value.
    logic [15:0] event_set; // Filtered edges seen this cycle.
    logic [15:0] mask_reg; // Event enable mask.
    logic event_clear; // Clear request for the event latch.
    logic summary_reg; // Registered summary message.
    logic [15:0] rd_data_reg; // Registered read answer.
    logic rd_valid_reg; // Read answer marker.

    // Condition vector: only the two serial summaries are wired.
    always_comb begin
        cond_next = csgeq_pkg::COND_RST;
        cond_next[csgeq_pkg::BIT_SER1] = SER1_SMB_I; // R02
        cond_next[csgeq_pkg::BIT_SER2] = SER2_SMB_I; // R03
        // The DSP link hardware is absent, so its bits stay low.
        cond_next[csgeq_pkg::BIT_TX_LINK] = 1'b0; // R04
        cond_next[csgeq_pkg::BIT_RX_LINK] = 1'b0; // R04
    end

    // Condition register samples every cycle; edges are found against it.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cond_reg <= csgeq_pkg::COND_RST;
        end else begin
            cond_reg <= cond_next & csgeq_pkg::IMPL_MASK; // R01
        end
    end

    // Edge filters select which transitions reach the event latch.
    assign event_set = ((cond_next & ~cond_reg & rise_reg) |
                        (~cond_next & cond_reg & fall_reg)) &
                       csgeq_pkg::IMPL_MASK; // R10

    // A query of the event latch or the clear-status command empties it.
    assign event_clear = CLS_I || (RD_STB_I && (REG_SEL_I == csgeq_pkg::SEL_EVENT)); // R07

    // New events win over a clear in the same cycle, so none is lost.
    assign event_next = (event_clear ? 16'h0000 : event_reg) | event_set; // R07 R10

    // Event latch.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            event_reg <= csgeq_pkg::EVENT_RST;
        end else begin
            event_reg <= event_next;
        end
    end

    // Writable registers; unused bits are dropped on the way in.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rise_reg <= csgeq_pkg::RISE_RST;
            fall_reg <= csgeq_pkg::FALL_RST;
            mask_reg <= csgeq_pkg::MASK_RST;
        end else if (WR_STB_I) begin
            case (REG_SEL_I)
                csgeq_pkg::SEL_RISE: begin
                    rise_reg <= WR_DATA_I & csgeq_pkg::IMPL_MASK; // R08 R01
                end
                csgeq_pkg::SEL_FALL: begin
                    fall_reg <= WR_DATA_I & csgeq_pkg::IMPL_MASK; // R08 R01
                end
                csgeq_pkg::SEL_MASK: begin
                    mask_reg <= WR_DATA_I & csgeq_pkg::IMPL_MASK; // R09 R01
                end
                default: begin
                    // Condition and event registers ignore writes.
                end
            endcase
        end
    end

    // Read answer; the event value is the one before the clear.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= RD_STB_I;
            if (RD_STB_I) begin
                case (REG_SEL_I)
                    csgeq_pkg::SEL_COND: rd_data_reg <= cond_reg;
                    csgeq_pkg::SEL_RISE: rd_data_reg <= rise_reg; // R08
                    csgeq_pkg::SEL_FALL: rd_data_reg <= fall_reg; // R08
                    csgeq_pkg::SEL_EVENT: rd_data_reg <= event_reg;
                    csgeq_pkg::SEL_MASK: rd_data_reg <= mask_reg; // R09
                    default: rd_data_reg <= 16'h0000;
                endcase
            end
        end
    end

    // Summary toward the parent hardware group; it only reaches the
    // status byte once the controller enables it there.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            summary_reg <= 1'b0;
        end else begin
            summary_reg <= |(event_reg & mask_reg); // R05 R10 R06
        end
    end

    assign RD_DATA_O = rd_data_reg;
    assign RD_VALID_O = rd_valid_reg;
    assign SUMMARY_MSG_O = summary_reg;

    logic [csgeq_pkg::ESR_ERR_W-1:0] esr_prev_reg; // Last error bits seen.
    logic push; // An error bit rose this cycle.
    logic pop; // A queue read removes an entry.
    logic full; // Queue holds twenty entries.
    logic empty; // Queue holds nothing.
    logic [csgeq_pkg::PTR_W-1:0] wr_ptr_reg; // Next free slot.
    logic [csgeq_pkg::PTR_W-1:0] rd_ptr_reg; // Oldest entry.
    logic [csgeq_pkg::PTR_W-1:0] cnt_reg; // Entries held.
    logic [csgeq_pkg::PTR_W-1:0] mem_waddr; // Write slot.
    logic [csgeq_pkg::ENTRY_W-1:0] mem_wdata; // Entry written.
    logic [csgeq_pkg::ENTRY_W-1:0] mem_rdata; // Entry read back.
    logic rd_stage_reg; // Queue read in flight.
    logic empty_stage_reg; // That read found the queue empty.
    logic [csgeq_pkg::CODE_W-1:0] err_code_reg; // Answer code.
    logic [csgeq_pkg::DESC_W-1:0] err_id_reg; // Answer description id.
    logic [csgeq_pkg::DESC_W-1:0] err_len_reg; // Answer description length.
    logic err_valid_reg; // Answer marker.

    assign full = (cnt_reg == csgeq_pkg::DEPTH_CNT); // R11
    assign empty = (cnt_reg == '0);

    // One entry per cycle in which any error bit rises, however many rise.
    assign push = |(ESR_ERR_I & ~esr_prev_reg); // R13
    assign pop = ERR_RD_STB_I && !empty; // R18

    // A full queue keeps its length and replaces the newest entry.
    assign mem_waddr = full ? ptr_dec(wr_ptr_reg) : wr_ptr_reg; // R16
    assign mem_wdata = full ?
        {csgeq_pkg::CODE_OVERFLOW, csgeq_pkg::DESC_ID_OVERFLOW,
         csgeq_pkg::DESC_LEN_OVERFLOW} : // R16
        {ERR_CODE_I, ERR_DESC_ID_I, ERR_DESC_LEN_I}; // R15

    // Previous error bits, for edge detection.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            esr_prev_reg <= '0;
        end else begin
            esr_prev_reg <= ESR_ERR_I;
        end
    end

    // Pointers and fill count. Only the count is kept internally; there is
    // deliberately no message-available output.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push && !full) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg); // R11
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg); // R18
            end
            case ({push && !full, pop})
                2'b10: cnt_reg <= cnt_reg + 5'h01;
                2'b01: cnt_reg <= cnt_reg - 5'h01; // R18
                default: cnt_reg <= cnt_reg; // R12
            endcase
        end
    end

    // Entry storage.
    csgeq_mem u_mem (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .we_i(push),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .re_i(pop),
        .raddr_i(rd_ptr_reg),
        .rdata_o(mem_rdata)
    );

    // First read stage: remember whether the read found anything.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rd_stage_reg <= 1'b0;
            empty_stage_reg <= 1'b0;
        end else begin
            rd_stage_reg <= ERR_RD_STB_I;
            empty_stage_reg <= empty;
        end
    end

    // Second read stage: the answer is held until the next read. Two stages
    // cost a cycle but keep the answer off the memory's output mux.
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            err_code_reg <= csgeq_pkg::CODE_NO_ERROR;
            err_id_reg <= csgeq_pkg::DESC_ID_NO_ERROR;
            err_len_reg <= csgeq_pkg::DESC_LEN_NO_ERROR;
            err_valid_reg <= 1'b0;
        end else begin
            err_valid_reg <= rd_stage_reg;
            if (rd_stage_reg && empty_stage_reg) begin
                err_code_reg <= csgeq_pkg::CODE_NO_ERROR; // R17
                err_id_reg <= csgeq_pkg::DESC_ID_NO_ERROR; // R17
                err_len_reg <= csgeq_pkg::DESC_LEN_NO_ERROR; // R17
            end else if (rd_stage_reg) begin
                err_code_reg <= mem_rdata[csgeq_pkg::CODE_LSB +: csgeq_pkg::CODE_W]; // R14
                err_id_reg <= mem_rdata[csgeq_pkg::DESC_ID_LSB +: csgeq_pkg::DESC_W]; // R14
                err_len_reg <= mem_rdata[csgeq_pkg::DESC_LEN_LSB +: csgeq_pkg::DESC_W]; // R15
            end
        end
    end

    // Number first, then description: the order the controller reads. R19
    assign ERR_CODE_O = err_code_reg;
    assign ERR_DESC_ID_O = err_id_reg;
    assign ERR_DESC_LEN_O = err_len_reg;
    assign ERR_VALID_O = err_valid_reg;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    // A write to the event mask.
    sequence s_mask_write;
        WR_STB_I && (REG_SEL_I == csgeq_pkg::SEL_MASK);
    endsequence

    // A read of the event mask.
    sequence s_mask_read;
        RD_STB_I && !WR_STB_I && (REG_SEL_I == csgeq_pkg::SEL_MASK);
    endsequence

    // A write to the rise filter.
    sequence s_rise_write;
        WR_STB_I && (REG_SEL_I == csgeq_pkg::SEL_RISE);
    endsequence

    chk_unused_bits_zero: assert property ( // R01
        RD_VALID_O |-> ((RD_DATA_O & ~csgeq_pkg::IMPL_MASK) == 16'h0000))
        else $error("Unused register bits read nonzero.");

    chk_cond_ser1: assert property ( // R02
        RD_STB_I && (REG_SEL_I == csgeq_pkg::SEL_COND) && $past(SER1_SMB_I) |=>
        RD_DATA_O[csgeq_pkg::BIT_SER1])
        else $error("Condition bit 9 does not follow serial group one.");

    chk_cond_ser2: assert property ( // R03
        RD_STB_I && (REG_SEL_I == csgeq_pkg::SEL_COND) && !$past(SER2_SMB_I) |=>
        !RD_DATA_O[csgeq_pkg::BIT_SER2])
        else $error("Condition bit 8 does not follow serial group two.");

    chk_link_bits_low: assert property ( // R04
        event_reg[1:0] == 2'b00)
        else $error("Link failure events were raised.");

    chk_summary_form: assert property ( // R05
        ##1 (SUMMARY_MSG_O == |($past(event_reg) & $past(mask_reg))))
        else $error("Summary does not match enabled events.");

    chk_event_clear: assert property ( // R07
        (CLS_I && (event_set == 16'h0000)) |=> (event_reg == 16'h0000))
        else $error("Event latch not cleared by clear-status.");

    chk_filter_rw: assert property ( // R08
        s_rise_write ##1 !WR_STB_I ##1
        (RD_STB_I && !WR_STB_I && (REG_SEL_I == csgeq_pkg::SEL_RISE)) |=>
        (RD_DATA_O == ($past(WR_DATA_I, 3) & csgeq_pkg::IMPL_MASK)))
        else $error("Rise filter read back differs from write.");

    chk_mask_rw: assert property ( // R09
        s_mask_write ##1 !WR_STB_I ##1 s_mask_read |=>
        (RD_DATA_O == ($past(WR_DATA_I, 3) & csgeq_pkg::IMPL_MASK)))
        else $error("Event mask read back differs from write.");

    chk_rise_event: assert property ( // R10
        (SER1_SMB_I && !cond_reg[csgeq_pkg::BIT_SER1] && rise_reg[csgeq_pkg::BIT_SER1]) |=>
        event_reg[csgeq_pkg::BIT_SER1])
        else $error("Filtered rising edge did not set its event.");

    chk_queue_bound: assert property ( // R11
        cnt_reg <= csgeq_pkg::DEPTH_CNT)
        else $error("Error queue count exceeds its depth.");

    chk_push_grows: assert property ( // R13
        (push && !full && !pop) |=> (cnt_reg == $past(cnt_reg) + 5'h01))
        else $error("Rising error bit did not add an entry.");

    chk_overflow_hold: assert property ( // R16
        (push && full && !pop) |=> (cnt_reg == csgeq_pkg::DEPTH_CNT) && $stable(wr_ptr_reg))
        else $error("Full queue grew or moved on overflow.");

    chk_empty_answer: assert property ( // R17
        (ERR_RD_STB_I && empty) |-> ##2 (ERR_VALID_O &&
        (ERR_CODE_O == csgeq_pkg::CODE_NO_ERROR)))
        else $error("Empty queue read did not answer no error.");

    chk_read_advance: assert property ( // R18
        (pop && !push) |=> (cnt_reg == $past(cnt_reg) - 5'h01) &&
        (rd_ptr_reg == ptr_inc($past(rd_ptr_reg))))
        else $error("Queue read did not remove the oldest entry.");

endmodule

// ===== rtl/csgeq_pkg.sv
package csgeq_pkg;

    // Width of every register in the status group.
    localparam int REG_W = 16;

    // Bits that hold real state; all others read as zero.
    localparam logic [15:0] IMPL_MASK = 16'h0303;

    // Condition bit positions.
    localparam int BIT_SER1 = 9;
    localparam int BIT_SER2 = 8;
    localparam int BIT_TX_LINK = 1;
    localparam int BIT_RX_LINK = 0;

    // Register selector codes on the command port.
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_COND = 3'h0;
    localparam logic [2:0] SEL_RISE = 3'h1;
    localparam logic [2:0] SEL_FALL = 3'h2;
    localparam logic [2:0] SEL_EVENT = 3'h3;
    localparam logic [2:0] SEL_MASK = 3'h4;

    // Reset values of the group registers.
    localparam logic [15:0] COND_RST = 16'h0000;
    localparam logic [15:0] RISE_RST = 16'h0303;
    localparam logic [15:0] FALL_RST = 16'h0000;
    localparam logic [15:0] EVENT_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;

    // Error queue geometry.
    localparam int QUEUE_DEPTH = 20;
    localparam int PTR_W = 5;
    localparam logic [4:0] DEPTH_CNT = 5'h14;
    localparam logic [4:0] LAST_IDX = 5'h13;
    localparam int ESR_ERR_W = 4;

    // Entry layout: code in the top half, then description id, then length.
    localparam int ENTRY_W = 32;
    localparam int CODE_W = 16;
    localparam int DESC_W = 8;
    localparam int CODE_LSB = 16;
    localparam int DESC_ID_LSB = 8;
    localparam int DESC_LEN_LSB = 0;

    // Fixed answers of the queue.
    localparam logic [15:0] CODE_NO_ERROR = 16'h0000;
    localparam logic [15:0] CODE_OVERFLOW = 16'hfea2;
    localparam logic [7:0] DESC_ID_NO_ERROR = 8'h00;
    localparam logic [7:0] DESC_ID_OVERFLOW = 8'h01;
    localparam logic [7:0] DESC_LEN_NO_ERROR = 8'h08;
    localparam logic [7:0] DESC_LEN_OVERFLOW = 8'h0e;
    localparam logic [7:0] DESC_LEN_MAX = 8'hff;

endpackage

// ===== rtl/csgeq_mem.sv
// Small queue storage; read data leave through a register.
module csgeq_mem (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic we_i,
    input wire logic [csgeq_pkg::PTR_W-1:0] waddr_i,
    input wire logic [csgeq_pkg::ENTRY_W-1:0] wdata_i,
    input wire logic re_i,
    input wire logic [csgeq_pkg::PTR_W-1:0] raddr_i,
    output logic [csgeq_pkg::ENTRY_W-1:0] rdata_o
);

    // Storage array; it needs no reset because nothing reads an unwritten slot.
    logic [csgeq_pkg::ENTRY_W-1:0] mem_reg [csgeq_pkg::QUEUE_DEPTH];

    // Write port.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_reg[waddr_i] <= wdata_i;
        end
    end

    // Registered read port.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= mem_reg[raddr_i];
        end
    end

endmodule

// ===== sim/csgeq_ctrl.sv
// Remote controller stand-in: issues register, clear-status and error queue requests.
module csgeq_ctrl (
    input wire logic clk_i,
    input wire logic [csgeq_pkg::REG_W-1:0] rd_data_i,
    input wire logic rd_valid_i,
    input wire logic summary_i,
    input wire logic [csgeq_pkg::CODE_W-1:0] err_code_i,
    input wire logic [csgeq_pkg::DESC_W-1:0] err_desc_id_i,
    input wire logic [csgeq_pkg::DESC_W-1:0] err_desc_len_i,
    input wire logic err_valid_i,
    output logic [csgeq_pkg::SEL_W-1:0] reg_sel_o,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output logic [csgeq_pkg::REG_W-1:0] wr_data_o,
    output logic cls_o,
    output logic err_rd_stb_o,
    output logic status_bit0_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Enable of this group in the parent hardware group, set before any event is awaited.
    logic parent_en = 1'b1;

    // Only an enabled summary may reach bit zero of the status byte.
    assign status_bit0_o = summary_i & parent_en;

    // All requests idle at time zero.
    initial begin
        reg_sel_o = 3'h0;
        rd_stb_o = 1'b0;
        wr_stb_o = 1'b0;
        wr_data_o = 16'h0000;
        cls_o = 1'b0;
        err_rd_stb_o = 1'b0;
    end

    // One write; select and data are scrambled afterwards so that stale values never help.
    task automatic reg_write(input logic [2:0] sel, input logic [15:0] data);
        @(posedge clk_i);
        reg_sel_o <= sel;
        wr_data_o <= data;
        wr_stb_o <= 1'b1;
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
        wr_data_o <= ~data;
        reg_sel_o <= ~sel;
    endtask

    // One read; the answer must stand at the falling edge half a cycle after the taking edge.
    task automatic reg_read(input logic [2:0] sel, output logic [15:0] data);
        @(posedge clk_i);
        reg_sel_o <= sel;
        rd_stb_o <= 1'b1;
        @(posedge clk_i);
        rd_stb_o <= 1'b0;
        reg_sel_o <= ~sel;
        @(negedge clk_i);
        data = rd_valid_i ? rd_data_i : 16'hxxxx;
    endtask

    // Clear-status common command as a single pulse.
    task automatic clear_status();
        @(posedge clk_i);
        cls_o <= 1'b1;
        @(posedge clk_i);
        cls_o <= 1'b0;
    endtask

    // Error query: a number is taken first, then the description, two cycles after the request.
    task automatic err_read(output logic [15:0] code, output logic [7:0] id,
                            output logic [7:0] len);
        @(posedge clk_i);
        err_rd_stb_o <= 1'b1;
        @(posedge clk_i);
        err_rd_stb_o <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        code = err_valid_i ? err_code_i : 16'hxxxx;
        id = err_valid_i ? err_desc_id_i : 8'hxx;
        len = err_valid_i ? err_desc_len_i : 8'hxx;
    endtask
endmodule

// ===== sim/comm_status_group_error_queue_tb.sv
// Self-checking bench: a model with ints and a queue is compared at every result.
module comm_status_group_error_queue_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ser1 = 1'b0;
    logic ser2 = 1'b0;
    logic [3:0] esr = 4'h0;
    logic [15:0] code_in = 16'h0000;
    logic [7:0] id_in = 8'h00;
    logic [7:0] len_in = 8'h00;
    wire logic [2:0] sel;
    wire logic rd_stb, wr_stb, cls, err_rd_stb, rd_valid, summary, err_valid;
    wire logic [15:0] wr_data, rd_data, err_code;
    wire logic [7:0] err_id, err_len;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    int unsigned seed = 32'h0000b8c1;
    // Model: 0 condition, 1 rise, 2 fall, 3 event, 4 mask, others read zero.
    int regs_m[8] = '{0, 16'h0303, 0, 0, 0, 0, 0, 0};
    logic [31:0] q_m[$];

    csgeq_top csgeq_top_i (.CLK_I(clk), .NRST_I(nrst), .SER1_SMB_I(ser1), .SER2_SMB_I(ser2),
        .REG_SEL_I(sel), .RD_STB_I(rd_stb), .WR_STB_I(wr_stb), .WR_DATA_I(wr_data),
        .CLS_I(cls), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .SUMMARY_MSG_O(summary),
        .ESR_ERR_I(esr), .ERR_CODE_I(code_in), .ERR_DESC_ID_I(id_in),
        .ERR_DESC_LEN_I(len_in), .ERR_RD_STB_I(err_rd_stb), .ERR_CODE_O(err_code),
        .ERR_DESC_ID_O(err_id), .ERR_DESC_LEN_O(err_len), .ERR_VALID_O(err_valid));

    csgeq_ctrl ctrl_i (.clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .summary_i(summary), .err_code_i(err_code), .err_desc_id_i(err_id),
        .err_desc_len_i(err_len), .err_valid_i(err_valid), .reg_sel_o(sel),
        .rd_stb_o(rd_stb), .wr_stb_o(wr_stb), .wr_data_o(wr_data), .cls_o(cls),
        .err_rd_stb_o(err_rd_stb), .status_bit0_o());

    // 200 MHz clock.
    always #2.5 clk = ~clk;

    // Hang guard; the full run needs under two thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    // Xorshift source so that every run sees the same stimulus.
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmp_entry(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Write through the controller; only filters and mask keep their implemented bits.
    task automatic wr(input int s, input logic [15:0] v);
        ctrl_i.reg_write(3'(s), v);
        if (s == 1 || s == 2 || s == 4) begin
            regs_m[s] = v & 16'h0303;
        end
    endtask

    // Read and compare; an event read empties the model's latch as well.
    task automatic rd_check(input int s);
        logic [15:0] rv;
        ctrl_i.reg_read(3'(s), rv);
        cmp_reg("register read", 16'(regs_m[s]), rv);
        if (s == 3) begin
            regs_m[3] = 0;
        end
    endtask

    // Move the serial summaries; filtered edges set event bits in the model.
    task automatic step_cond(input logic n1, input logic n2);
        int nv;
        nv = (int'(n1) << 9) | (int'(n2) << 8);
        regs_m[3] |= (nv & ~regs_m[0] & regs_m[1]) | (~nv & regs_m[0] & regs_m[2]);
        regs_m[0] = nv;
        @(posedge clk);
        ser1 <= n1;
        ser2 <= n2;
    endtask

    // One error: the bit stays high two cycles, which must still give a single entry.
    task automatic push(input int k);
        logic [31:0] e;
        e = rnd();
        @(posedge clk);
        esr <= 4'h1 << k;
        code_in <= e[31:16];
        id_in <= e[15:8];
        len_in <= e[7:0];
        repeat (2) @(posedge clk);
        esr <= 4'h0;
        code_in <= ~e[31:16];
        if (q_m.size() < 20) begin
            q_m.push_back(e);
        end else begin
            q_m[19] = {16'(-350), csgeq_pkg::DESC_ID_OVERFLOW, csgeq_pkg::DESC_LEN_OVERFLOW};
        end
    endtask

    // One error query against the model queue.
    task automatic pop_check();
        logic [15:0] c;
        logic [7:0] d;
        logic [7:0] l;
        ctrl_i.err_read(c, d, l);
        if (q_m.size() == 0) begin
            cmp_entry("empty queue", {16'h0000, 8'h00, 8'h08}, {c, d, l});
        end else begin
            cmp_entry("queue entry", q_m.pop_front(), {c, d, l});
        end
    endtask

    // Main sequence: reset, registers, condition and events, then the error queue.
    initial begin
        logic [31:0] ev;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        cmp_entry("reset answer", {16'h0000, 8'h00, 8'h08}, {err_code, err_id, err_len});
        cmp_bit("reset summary", 1'b0, summary);
        for (int s = 0; s < 8; s++) begin
            rd_check(s);
        end
        // Random words to every select, read-only and unmapped ones included.
        for (int n = 0; n < 3; n++) begin
            for (int s = 0; s < 8; s++) begin
                ev = rnd();
                wr(s, ev[15:0]);
            end
            for (int s = 0; s < 8; s++) begin
                rd_check(s);
            end
            // A read right behind a write must already see the new word.
            wr(1, ev[31:16]);
            rd_check(1);
            wr(4, ev[15:0]);
            rd_check(4);
        end
        // Serial summaries move while filters and mask change now and then.
        for (int n = 0; n < 48; n++) begin
            ev = rnd();
            if (n % 4 == 0) begin
                wr(1, ev[31:16]);
                wr(2, ~ev[31:16]);
                wr(4, ev[15:0]);
            end
            step_cond(ev[9], ev[8]);
            repeat (3) @(posedge clk);
            @(negedge clk);
            cmp_bit("summary", (regs_m[3] & regs_m[4]) != 0, summary);
            if (ev[3]) begin
                ctrl_i.clear_status();
                regs_m[3] = 0;
            end else begin
                rd_check(ev[2] ? 3 : 0);
            end
        end
        // Queue rounds; the first one overflows and then drains past empty.
        pop_check();
        for (int r = 0; r < 6; r++) begin
            ev = rnd();
            for (int n = 0; n < ((r == 0) ? 22 : int'(ev[4:0])); n++) begin
                push(n % 4);
            end
            for (int n = 0; n < ((r == 0) ? 21 : int'(ev[9:5])); n++) begin
                pop_check();
            end
        end
        results();
    end
endmodule
